// ==== tpf_framer.sv ====
// Trace packet framer for instrumentation and watchpoint trace units
`timescale 1ns/1ps
`default_nettype none

module tpf_framer
   import tpf_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Stimulus register writes
   input wire logic stim_valid,
   output logic stim_ready,
   input wire logic [4:0] stim_port,
   input wire logic [2:0] stim_page,
   input wire logic [1:0] stim_size,
   input wire logic [31:0] stim_data,
   // Data trace events
   input wire logic hw_valid,
   output logic hw_ready,
   input wire logic [4:0] hw_disc,
   input wire logic [1:0] hw_size,
   input wire logic [31:0] hw_data,
   // Sampling, wrap, timestamp and sync requests
   input wire logic prog_sample,
   input wire logic [31:0] program_counter,
   input wire logic [7:0] cnt_wrap,
   input wire logic ts_req,
   input wire logic sync_req,
   // Byte stream to trace port unit
   output logic byte_valid,
   input wire logic byte_ready,
   output logic [7:0] byte_data
);
   // ************************************************************
   // State
   // ************************************************************
   tpf_state_t st_r, st_nxt;
   logic [7:0] pkt_r [6];
   logic [7:0] pkt_nxt [6];
   logic [2:0] len_r, len_nxt, idx_r, idx_nxt;
   logic sync_r, sync_nxt, ovf_r, ovf_nxt, turn_r, turn_nxt;
   logic tsp_r, tsp_nxt, syp_r, syp_nxt, pcp_r, pcp_nxt;
   logic wrp_r, wrp_nxt;
   logic [31:0] pcv_r, pcv_nxt;
   logic [7:0] wrv_r, wrv_nxt;
   logic [2:0] page_r, page_nxt;
   logic [TS_W-1:0] ts_r, ts_nxt;
   logic sr_r, sr_nxt, hr_r, hr_nxt;
   logic take_s, take_h, push, b_ready, lost, ts_load;
   logic [2:0] b, g;

   assign stim_ready = sr_r;
   assign hw_ready = hr_r;
   assign push = (st_r == TPF_SEND) && b_ready;

   // ************************************************************
   // Packet builder
   // ************************************************************
   always_comb begin
      st_nxt = st_r;
      len_nxt = len_r;
      idx_nxt = idx_r;
      sync_nxt = sync_r;
      pkt_nxt = pkt_r;
      page_nxt = page_r;
      ts_load = 1'b0;
      b = 3'h0;
      g = 3'h1;
      take_s = stim_valid && sr_r;
      take_h = hw_valid && hr_r;
      if (push) begin
         idx_nxt = idx_r + 3'h1;
         if (idx_r + 3'h1 == len_r) begin
            st_nxt = TPF_IDLE;
         end
      end
      if (st_r == TPF_IDLE) begin
         idx_nxt = 3'h0;
         sync_nxt = 1'b0;
         if (take_s) begin
            st_nxt = TPF_SEND;
            if (stim_page != page_r) begin
               pkt_nxt[0] = {1'b0, stim_page, 1'b1, 1'b0, 2'h0};
               page_nxt = stim_page;
               b = 3'h1;
            end
            pkt_nxt[b] = {stim_port, 1'b0, stim_size};
            for (int i = 0; i < 4; i++) begin
               pkt_nxt[3'(i) + b + 3'h1] = stim_data[8*i +: 8];
            end
            len_nxt = b + 3'h1 + tpf_size_bytes(stim_size);
         end else if (take_h) begin
            st_nxt = TPF_SEND;
            pkt_nxt[0] = {hw_disc, 1'b1, hw_size};
            for (int i = 0; i < 4; i++) begin
               pkt_nxt[i + 1] = hw_data[8*i +: 8];
            end
            len_nxt = 3'h1 + tpf_size_bytes(hw_size);
         end else if (syp_r) begin
            st_nxt = TPF_SEND;
            sync_nxt = 1'b1;
            for (int i = 0; i < 5; i++) begin
               pkt_nxt[i] = SYNC_ZERO;
            end
            pkt_nxt[5] = SYNC_LAST;
            len_nxt = SYNC_LEN;
            page_nxt = 3'h0;
         end else if (ovf_r) begin
            st_nxt = TPF_SEND;
            pkt_nxt[0] = HDR_OVF;
            len_nxt = 3'h1;
         end else if (tsp_r) begin
            st_nxt = TPF_SEND;
            ts_load = 1'b1;
            if (ts_r != '0 && ts_r <= TS_W'(TS_SHORT_MAX)) begin
               pkt_nxt[0] = {1'b0, ts_r[2:0], NIB_TS};
               len_nxt = 3'h1;
            end else begin
               pkt_nxt[0] = HDR_TS_LONG;
               for (int i = 1; i < 4; i++) begin
                  if ((ts_r >> (TS_GRP * i)) != '0) begin
                     g = 3'(i + 1);
                  end
               end
               for (int i = 0; i < 4; i++) begin
                  pkt_nxt[i + 1] = {3'(i) + 3'h1 < g,
                                    ts_r[TS_GRP*i +: TS_GRP]};
               end
               len_nxt = g + 3'h1;
            end
         end else if (wrp_r) begin
            st_nxt = TPF_SEND;
            pkt_nxt[0] = {DISC_WRAP, 1'b1, SZ_8};
            pkt_nxt[1] = wrv_r;
            len_nxt = 3'h2;
         end else if (pcp_r) begin
            st_nxt = TPF_SEND;
            pkt_nxt[0] = {DISC_PROG, 1'b1, SZ_32};
            for (int i = 0; i < 4; i++) begin
               pkt_nxt[i + 1] = pcv_r[8*i +: 8];
            end
            len_nxt = PKT_MAX;
         end
      end
   end

   // ************************************************************
   // Event latches, timestamp counter, ready flags
   // ************************************************************
   always_comb begin
      lost = 1'b0;
      syp_nxt = syp_r || sync_req;
      if (sync_nxt && st_r == TPF_IDLE) begin
         syp_nxt = sync_req;
      end
      tsp_nxt = (tsp_r && !ts_load) || ts_req;
      pcp_nxt = pcp_r;
      pcv_nxt = pcv_r;
      wrp_nxt = wrp_r;
      wrv_nxt = wrv_r;
      if (st_r == TPF_IDLE && !take_s && !take_h && !syp_r && !ovf_r
          && !tsp_r) begin
         if (wrp_r) begin
            wrp_nxt = 1'b0;
         end else begin
            pcp_nxt = 1'b0;
         end
      end
      if (prog_sample) begin
         lost = lost || pcp_nxt;
         pcp_nxt = 1'b1;
         pcv_nxt = program_counter;
      end
      if (cnt_wrap != 8'h00) begin
         lost = lost || wrp_nxt;
         wrp_nxt = 1'b1;
         wrv_nxt = cnt_wrap;
      end
      ts_nxt = ts_load ? '0 : ts_r + TS_W'(1);
      if (!ts_load && ts_r == '1) begin
         lost = 1'b1;
      end
      ovf_nxt = ovf_r;
      if (st_r == TPF_IDLE && !take_s && !take_h && !syp_r) begin
         ovf_nxt = 1'b0;
      end
      ovf_nxt = ovf_nxt || lost;
      turn_nxt = turn_r ^ (st_nxt == TPF_IDLE);
      sr_nxt = (st_nxt == TPF_IDLE) && !turn_r && !take_s && !take_h
               && !syp_nxt && !ovf_nxt && !tsp_nxt
               && !wrp_nxt && !pcp_nxt;
      hr_nxt = (st_nxt == TPF_IDLE) && turn_r && !take_s && !take_h
               && !syp_nxt && !ovf_nxt && !tsp_nxt
               && !wrp_nxt && !pcp_nxt;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= TPF_IDLE;
         for (int i = 0; i < 6; i++) begin
            pkt_r[i] <= 8'h00;
         end
         len_r <= 3'h0;
         idx_r <= 3'h0;
         sync_r <= 1'b0;
         ovf_r <= 1'b0;
         turn_r <= 1'b0;
         tsp_r <= 1'b0;
         syp_r <= 1'b0;
         pcp_r <= 1'b0;
         wrp_r <= 1'b0;
         pcv_r <= 32'h0000_0000;
         wrv_r <= 8'h00;
         page_r <= 3'h0;
         ts_r <= '0;
         sr_r <= 1'b0;
         hr_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         pkt_r <= pkt_nxt;
         len_r <= len_nxt;
         idx_r <= idx_nxt;
         sync_r <= sync_nxt;
         ovf_r <= ovf_nxt;
         turn_r <= turn_nxt;
         tsp_r <= tsp_nxt;
         syp_r <= syp_nxt;
         pcp_r <= pcp_nxt;
         wrp_r <= wrp_nxt;
         pcv_r <= pcv_nxt;
         wrv_r <= wrv_nxt;
         page_r <= page_nxt;
         ts_r <= ts_nxt;
         sr_r <= sr_nxt;
         hr_r <= hr_nxt;
      end
   end

   // ************************************************************
   // Output buffer
   // ************************************************************
   tpf_buf u_buf (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .in_valid(st_r == TPF_SEND),
      .in_ready(b_ready),
      .in_data(pkt_r[idx_r]),
      .out_valid(byte_valid),
      .out_ready(byte_ready),
      .out_data(byte_data)
   );

   // ************************************************************
   // Checks
   // ************************************************************
   logic [2:0] ccnt_r;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ccnt_r <= 3'h0;
      end else if (push && !sync_r && pkt_r[0][3:0] == NIB_TS) begin
         ccnt_r <= (idx_r == 3'h0) ? 3'(pkt_r[0][C_BIT])
                   : ccnt_r + 3'(pkt_r[idx_r][C_BIT]);
      end
   end

   property p_len;
      @(posedge ref_clk) disable iff (!resetn)
      (st_r == TPF_SEND && !sync_r) |-> len_r <= PKT_MAX + 3'h1;
   endproperty
   a_len: assert property (p_len) else $error("packet too long");

   property p_sync;
      @(posedge ref_clk) disable iff (!resetn)
      (push && sync_r) |-> pkt_r[idx_r] ==
         ((idx_r == SYNC_LEN - 3'h1) ? SYNC_LAST : SYNC_ZERO);
   endproperty
   a_sync: assert property (p_sync) else $error("bad sync byte");

   property p_ovf;
      @(posedge ref_clk) disable iff (!resetn)
      (st_r == TPF_IDLE && !sr_r && !hr_r && !syp_r && ovf_r)
      |=> pkt_r[0] == HDR_OVF && len_r == 3'h1;
   endproperty
   a_ovf: assert property (p_ovf) else $error("bad overflow");

   property p_ts;
      @(posedge ref_clk) disable iff (!resetn)
      ts_load |=> pkt_r[0][3:0] == NIB_TS && pkt_r[0][6:4] != 3'h0
                  && ts_r == '0;
   endproperty
   a_ts: assert property (p_ts) else $error("bad timestamp");

   property p_rsv;
      @(posedge ref_clk) disable iff (!resetn)
      (push && idx_r == 3'h0 && !sync_r) |-> pkt_r[0][3:0] != NIB_RSV;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved header");

   property p_stim;
      @(posedge ref_clk) disable iff (!resetn)
      (take_s && stim_page == page_r) |=> pkt_r[0][SRC_BIT] == 1'b0
         && len_r == 3'h1 + tpf_size_bytes($past(stim_size));
   endproperty
   a_stim: assert property (p_stim) else $error("bad stimulus");

   property p_hw;
      @(posedge ref_clk) disable iff (!resetn)
      take_h |=> pkt_r[0][SRC_BIT] && pkt_r[0][1:0] == $past(hw_size);
   endproperty
   a_hw: assert property (p_hw) else $error("bad hw header");

   property p_cont;
      @(posedge ref_clk) disable iff (!resetn)
      ccnt_r <= 3'h4;
   endproperty
   a_cont: assert property (p_cont) else $error("too many C bits");

   property p_hold;
      @(posedge ref_clk) disable iff (!resetn)
      (byte_valid && !byte_ready) |=> byte_valid && $stable(byte_data);
   endproperty
   a_hold: assert property (p_hold) else $error("byte dropped");
endmodule // tpf_framer

`default_nettype wire

// ==== tpf_pkg.sv ====
// Constants, types and helpers for the trace packet framer
`default_nettype none

package tpf_pkg;
   localparam logic [7:0] HDR_OVF = 8'h70;
   localparam logic [7:0] HDR_TS_LONG = 8'hc0;
   localparam logic [7:0] SYNC_ZERO = 8'h00;
   localparam logic [7:0] SYNC_LAST = 8'h80;
   localparam logic [2:0] SYNC_LEN = 3'h6;
   localparam logic [2:0] PKT_MAX = 3'h5;
   localparam logic [3:0] NIB_TS = 4'h0;
   localparam logic [3:0] NIB_RSV = 4'h4;
   localparam int C_BIT = 7;
   localparam int SRC_BIT = 2;
   localparam int EXT_BIT = 3;
   localparam int TS_W = 28;
   localparam int TS_GRP = 7;
   localparam logic [1:0] SZ_INV = 2'h0;
   localparam logic [1:0] SZ_8 = 2'h1;
   localparam logic [1:0] SZ_16 = 2'h2;
   localparam logic [1:0] SZ_32 = 2'h3;
   localparam logic [4:0] DISC_PROG = 5'h02;
   localparam logic [4:0] DISC_WRAP = 5'h01;
   localparam logic [2:0] TS_SHORT_MAX = 3'h6;
   localparam int BUF_DEPTH = 2;

   typedef enum logic {TPF_IDLE, TPF_SEND} tpf_state_t;

   // Payload bytes for a size code
   function automatic logic [2:0] tpf_size_bytes(input logic [1:0] sz);
      case (sz)
         SZ_8: tpf_size_bytes = 3'h1;
         SZ_16: tpf_size_bytes = 3'h2;
         SZ_32: tpf_size_bytes = 3'h4;
         default: tpf_size_bytes = 3'h0;
      endcase
   endfunction
endpackage

`default_nettype wire


// ==== tpf_buf.sv ====
// Two-entry byte buffer between the packet builder and the trace port
`timescale 1ns/1ps
`default_nettype none

module tpf_buf
   import tpf_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [7:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [7:0] out_data
);
   // ****************************************
   // Storage
   // ****************************************
   logic [7:0] d0_r, d0_nxt, d1_r, d1_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic vld_r, vld_nxt;
   logic push, pop;

   // Valid comes straight from a flip-flop that tracks a nonzero count
   assign out_valid = vld_r;
   assign in_ready = (cnt_r != 2'(BUF_DEPTH));
   assign out_data = d0_r;

   always_comb begin
      push = in_valid && in_ready;
      pop = vld_r && out_ready;
      d0_nxt = d0_r;
      d1_nxt = d1_r;
      cnt_nxt = cnt_r + 2'(push) - 2'(pop);
      if (pop) begin
         d0_nxt = d1_r;
      end
      if (push) begin
         if (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop)) begin
            d0_nxt = in_data;
         end else begin
            d1_nxt = in_data;
         end
      end
      vld_nxt = (cnt_nxt != 2'h0);
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         d0_r <= 8'h00;
         d1_r <= 8'h00;
         cnt_r <= 2'h0;
         vld_r <= 1'b0;
      end else begin
         d0_r <= d0_nxt;
         d1_r <= d1_nxt;
         cnt_r <= cnt_nxt;
         vld_r <= vld_nxt;
      end
   end
endmodule // tpf_buf

`default_nettype wire

// ==== tpf_rx_model.sv ====
// Trace port unit model that takes framer bytes with stall modes
`timescale 1ns/1ps
`default_nettype none

module tpf_rx_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Byte stream from framer
   input wire logic byte_valid,
   output logic byte_ready,
   input wire logic [7:0] byte_data,
   // Stall mode: 0 prompt, 1 slow, 2 stopped
   input wire logic [1:0] mode
);
   // ****************************************
   // Receiver
   // ****************************************
   logic [7:0] q[$];
   logic [7:0] ser;
   logic tick;
   int i;
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         byte_ready <= 1'b0;
         tick <= 1'b0;
      end else begin
         if (byte_valid && byte_ready) begin
            // Wire carries bit 0 first; shift back into place
            for (i = 0; i < 8; i++) begin
               ser = {byte_data[i], ser[7:1]};
            end
            q.push_back(ser);
         end
         tick <= !tick;
         byte_ready <= (mode == 2'h0) || (mode == 2'h1 && tick);
      end
   end
endmodule // tpf_rx_model

`default_nettype wire

// ==== tpf_framer_tb.sv ====
// Self-checking bench for the trace packet framer
`timescale 1ns/1ps
`default_nettype none

module tpf_framer_tb
   import tpf_pkg::*;
;
   // ****************************************
   // Signals and instances
   // ****************************************
   typedef struct packed {
      logic src;
      logic [4:0] adr;
      logic [2:0] pg;
      logic [1:0] sz;
      logic [31:0] d;
   } tpf_row_t;
   logic ref_clk, resetn, stim_valid, stim_ready, hw_valid, hw_ready;
   logic prog_sample, ts_req, sync_req, byte_valid, byte_ready;
   logic [4:0] stim_port, hw_disc;
   logic [2:0] stim_page, cur_pg;
   logic [1:0] stim_size, hw_size, mode;
   logic [31:0] stim_data, hw_data, program_counter;
   logic [7:0] cnt_wrap, byte_data, held;
   logic [7:0] exp_q[$];
   int miscompares, n_compared, i, v1, v2;
   tpf_row_t rows[8];
   tpf_framer dut (.ref_clk, .resetn, .stim_valid, .stim_ready, .stim_port,
      .stim_page, .stim_size, .stim_data, .hw_valid, .hw_ready, .hw_disc,
      .hw_size, .hw_data, .prog_sample, .program_counter, .cnt_wrap, .ts_req,
      .sync_req, .byte_valid, .byte_ready, .byte_data);
   tpf_rx_model rx (.ref_clk, .resetn, .byte_valid, .byte_ready,
      .byte_data, .mode);
   always #2.5 ref_clk = ~ref_clk;
   // ****************************************
   // Tasks
   // ****************************************
   task automatic wrap_up();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] g, e, input string s);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %0t: %s got %h want %h", $time, s, g, e);
      end
   endtask
   task automatic chk1(input logic g, e, input string s);
      chk8({7'h0, g}, {7'h0, e}, s);
   endtask
   task automatic wait_bytes(input int n);
      int k;
      for (k = 0; k < 400 && rx.q.size() < n; k++)
         @(negedge ref_clk);
      if (rx.q.size() < n) begin
         chk1(1'b0, 1'b1, "byte wait ran out");
         wrap_up();
      end
   endtask
   task automatic pulse(ref logic s);
      @(negedge ref_clk);
      s = 1'b1;
      @(negedge ref_clk);
      s = 1'b0;
   endtask
   task automatic send(input tpf_row_t r);
      int k;
      @(negedge ref_clk);
      {stim_port, hw_disc, stim_page} = {r.adr, r.adr, r.pg};
      {stim_size, hw_size, stim_data, hw_data} = {r.sz, r.sz, r.d, r.d};
      {stim_valid, hw_valid} = {!r.src, r.src};
      for (k = 0; k < 50 && (r.src ? hw_ready : stim_ready) !== 1'b1; k++)
         @(negedge ref_clk);
      chk1(k < 50, 1'b1, "request not taken");
      if (k >= 50)
         wrap_up();
      @(negedge ref_clk);
      {stim_valid, hw_valid} = 2'h0;
   endtask
   task automatic expect_row(input tpf_row_t r);
      int n;
      if (!r.src && r.pg !== cur_pg) begin
         exp_q.push_back({1'b0, r.pg, 4'h8});
         cur_pg = r.pg;
      end
      exp_q.push_back({r.adr, r.src, r.sz});
      n = (r.sz == SZ_8) ? 1 : (r.sz == SZ_16) ? 2 : 4;
      for (int j = 0; j < n; j++)
         exp_q.push_back(r.d[8*j +: 8]);
   endtask
   task automatic check_q(input string s);
      wait_bytes(exp_q.size());
      repeat (4) @(negedge ref_clk);
      chk8(8'(rx.q.size()), 8'(exp_q.size()), s);
      foreach (exp_q[j])
         chk8(rx.q[j], exp_q[j], s);
      rx.q.delete();
      exp_q.delete();
      $display("test done: %s", s);
   endtask
   task automatic get_ts(output int v);
      logic [7:0] b;
      int n;
      wait_bytes(1);
      b = rx.q.pop_front();
      chk8({4'h0, b[3:0]}, {4'h0, NIB_TS}, "ts header");
      v = b[7] ? 0 : int'(b[6:4]);
      if (!b[7])
         chk1(v != 0, 1'b1, "ts value zero");
      for (n = 0; b[7] && n < 5; n++) begin
         wait_bytes(1);
         b = rx.q.pop_front();
         v = v | (int'(b[6:0]) << (7 * n));
      end
      chk1(n <= 4, 1'b1, "too many continuations");
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      rows = '{'{1'b0, 5'h01, 3'h0, SZ_8, 32'h000000a5},
         '{1'b0, 5'h1f, 3'h0, SZ_16, 32'h0000c3b2},
         '{1'b0, 5'h00, 3'h3, SZ_32, 32'h8f7e6d5c},
         '{1'b1, 5'h03, 3'h0, SZ_8, 32'h0000005a},
         '{1'b1, 5'h10, 3'h0, SZ_16, 32'h00001e2d},
         '{1'b0, 5'h0a, 3'h7, SZ_32, 32'hffffffff},
         '{1'b1, 5'h1f, 3'h0, SZ_32, 32'h01020304},
         '{1'b0, 5'h0a, 3'h0, SZ_8, 32'h00000080}};
      {ref_clk, resetn, stim_valid, hw_valid} = 4'h0;
      {prog_sample, ts_req, sync_req, cur_pg} = 6'h0;
      {stim_port, hw_disc, stim_page, stim_size, hw_size, mode} = 19'h0;
      {stim_data, hw_data, program_counter, cnt_wrap} = 104'h0;
      miscompares = 0;
      n_compared = 0;
      repeat (8) @(negedge ref_clk);
      chk1(byte_valid, 1'b0, "valid in reset");
      chk1(stim_ready | hw_ready, 1'b0, "ready in reset");
      resetn = 1'b1;
      $display("test done: reset");
      foreach (rows[j]) begin
         mode = 2'(j % 2);
         expect_row(rows[j]);
         send(rows[j]);
         check_q("table row");
      end
      mode = 2'h1;
      expect_row(rows[1]);
      expect_row(rows[4]);
      send(rows[1]);
      send(rows[4]);
      check_q("back to back");
      mode = 2'h2;
      expect_row(rows[2]);
      send(rows[2]);
      program_counter = 32'h1234abcd;
      pulse(prog_sample);
      pulse(prog_sample);
      repeat (4) @(negedge ref_clk);
      held = byte_data;
      chk1(byte_valid, 1'b1, "valid while stalled");
      repeat (4) @(negedge ref_clk);
      chk8(byte_data, held, "data held");
      exp_q.push_back(HDR_OVF);
      exp_q.push_back({DISC_PROG, 1'b1, SZ_32});
      for (i = 0; i < 4; i++)
         exp_q.push_back(program_counter[8*i +: 8]);
      mode = 2'h0;
      check_q("stall and overflow");
      pulse(sync_req);
      for (i = 0; i < 5; i++)
         exp_q.push_back(SYNC_ZERO);
      exp_q.push_back(SYNC_LAST);
      check_q("sync");
      cur_pg = 3'h0;
      expect_row(rows[2]);
      send(rows[2]);
      check_q("page after sync");
      @(negedge ref_clk);
      cnt_wrap = 8'h04;
      @(negedge ref_clk);
      cnt_wrap = 8'h00;
      wait_bytes(2);
      chk8(rx.q[0], {DISC_WRAP, 1'b1, SZ_8}, "wrap header");
      chk8(rx.q[1], 8'h04, "wrap payload");
      rx.q.delete();
      pulse(ts_req);
      repeat (2) @(negedge ref_clk);
      pulse(ts_req);
      get_ts(v1);
      get_ts(v2);
      chk1(v2 < v1 && v2 < 16, 1'b1, "delta after clear");
      $display("test done: timestamp");
      wrap_up();
   end
endmodule // tpf_framer_tb

`default_nettype wire
